/* core/rtc_sram_pkg.sv */
/*
  constants for the byte-wide memory with calendar clock: map, field positions, timing counts.
  assumes a 200 mhz mclk.
*/
package rtc_sram_pkg;
  localparam int          ADDR_W        = 11;
  localparam int          DATA_W        = 8;
  localparam int          DEPTH         = 2048;
  localparam logic [10:0] CTRL_ADDR     = 11'h7f8;
  localparam logic [10:0] SEC_ADDR      = 11'h7f9;
  localparam logic [10:0] MIN_ADDR      = 11'h7fa;
  localparam logic [10:0] HOUR_ADDR     = 11'h7fb;
  localparam logic [10:0] DOW_ADDR      = 11'h7fc;
  localparam logic [10:0] DATE_ADDR     = 11'h7fd;
  localparam logic [10:0] MONTH_ADDR    = 11'h7fe;
  localparam logic [10:0] YEAR_ADDR     = 11'h7ff;
  localparam logic [7:0]  CLK_BASE_HI   = 8'hff;
  localparam int          CTRL_LOAD_BIT = 7;
  localparam int          CTRL_READ_BIT = 6;
  localparam int          SEC_STOP_BIT  = 7;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  SEC_RESET     = 8'h80;
  localparam logic [7:0]  DATE_RESET    = 8'h01;
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          PF_DELAY_US   = 50;
  localparam int          PF_DELAY_CYC  = (PF_DELAY_US * 1000000) / CLK_PERIOD_PS;
  localparam int          RECOVERY_MS   = 2;
  localparam int          RECOVERY_CYC  = (RECOVERY_MS * 1000000) / (CLK_PERIOD_PS / 1000);
endpackage : rtc_sram_pkg

/* core/rtc_sram_mem.sv */
/*
  2048 x 8 storage array with registered read data.
  assumes one clock; write and read in the same cycle return old data.
*/
module rtc_sram_mem (
  input  wire logic                              mclk,
  input  wire logic                              we,
  input  wire logic [rtc_sram_pkg::ADDR_W-1:0]   addr,
  input  wire logic [rtc_sram_pkg::DATA_W-1:0]   wdata,
  output logic      [rtc_sram_pkg::DATA_W-1:0]   rdata
);
  import rtc_sram_pkg::*;
  logic [DATA_W-1:0] mem [DEPTH];
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : rtc_sram_mem

/* core/rtc_counters.sv */
/*
  real time counters in bcd: seconds to year, 24 hour, month lengths with leap years.
  assumes tick is a one-cycle pulse; load takes precedence over tick.
*/
module rtc_counters (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic [7:0] ld_sec,
  input  wire logic [7:0] ld_min,
  input  wire logic [7:0] ld_hour,
  input  wire logic [7:0] ld_dow,
  input  wire logic [7:0] ld_date,
  input  wire logic [7:0] ld_month,
  input  wire logic [7:0] ld_year,
  output logic      [7:0] sec_r,
  output logic      [7:0] min_r,
  output logic      [7:0] hour_r,
  output logic      [7:0] dow_r,
  output logic      [7:0] date_r,
  output logic      [7:0] month_r,
  output logic      [7:0] year_r
);
  import rtc_sram_pkg::*;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] >= 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = ((y[4] == 1'b0) && (y[1:0] == 2'b00)) || ((y[4] == 1'b1) && (y[1:0] == 2'b10));
    if (m == 8'h02) begin
      month_len = leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      month_len = 8'h30;
    end else begin
      month_len = 8'h31;
    end
  endfunction : month_len

  wire       stopped  = sec_r[SEC_STOP_BIT];
  wire       adv      = tick && !stopped;
  wire       sec_wrap = (sec_r[6:0] == 7'h59);
  wire       min_wrap = sec_wrap && (min_r == 8'h59);
  wire       hr_wrap  = min_wrap && (hour_r == 8'h23);
  wire       day_wrap = hr_wrap && (date_r == month_len(month_r, year_r));
  wire       mon_wrap = day_wrap && (month_r == 8'h12);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sec_r   <= SEC_RESET;
      min_r   <= 8'h00;
      hour_r  <= 8'h00;
      dow_r   <= DATE_RESET;
      date_r  <= DATE_RESET;
      month_r <= DATE_RESET;
      year_r  <= 8'h00;
    end else if (load) begin
      sec_r   <= ld_sec;
      min_r   <= ld_min;
      hour_r  <= ld_hour;
      dow_r   <= ld_dow;
      date_r  <= ld_date;
      month_r <= ld_month;
      year_r  <= ld_year;
    end else if (adv) begin
      sec_r <= sec_wrap ? 8'h00 : bcd_inc(sec_r);
      if (sec_wrap) begin
        min_r <= min_wrap ? 8'h00 : bcd_inc(min_r);
      end
      if (min_wrap) begin
        hour_r <= hr_wrap ? 8'h00 : bcd_inc(hour_r);
      end
      if (hr_wrap) begin
        dow_r  <= (dow_r == 8'h07) ? 8'h01 : bcd_inc(dow_r);
        date_r <= day_wrap ? 8'h01 : bcd_inc(date_r);
      end
      if (day_wrap) begin
        month_r <= mon_wrap ? 8'h01 : bcd_inc(month_r);
      end
      if (mon_wrap) begin
        year_r <= (year_r == 8'h99) ? 8'h00 : bcd_inc(year_r);
      end
    end
  end
endmodule : rtc_counters

/* core/rtc_sram.sv */
/*
  byte-wide static memory with a calendar clock in the top eight bytes.
  assumes strobes, address, data, power-fail flag and oscillator level are synchronous to mclk.
*/
module rtc_sram (
  input  wire logic                            mclk,
  input  wire logic                            rst,
  input  wire logic                            chip_sel_n,
  input  wire logic                            out_en_n,
  input  wire logic                            write_n,
  input  wire logic [rtc_sram_pkg::ADDR_W-1:0] addr_pins,
  input  wire logic [rtc_sram_pkg::DATA_W-1:0] data_pins_in,
  output logic      [rtc_sram_pkg::DATA_W-1:0] data_pins_out,
  output logic                                 data_pins_oe,
  input  wire logic                            power_fail,
  input  wire logic                            osc_in,
  output logic                                 power_fail_active_r
);
  import rtc_sram_pkg::*;

  typedef enum logic [1:0] {IDLE, REFRESH, LOAD} upd_e;

  upd_e              upd_r;
  logic [7:0]        ctrl_r;
  logic [7:0]        hold_r [8];
  logic              osc_d_r;
  logic              pf_blk_r;
  logic              rd_sel_r;
  logic              rd_clk_r;
  logic [2:0]        rd_idx_r;
  logic              prev_we_r;
  logic [7:0]        mem_rdata;
  logic [7:0]        c_sec, c_min, c_hour, c_dow, c_date, c_month, c_year;
  logic [7:0]        data_pins_out_nxt;

  // power fail blocks at once; pf_blk_r gives the delayed view
  wire       blocked    = power_fail || pf_blk_r;
  wire       selected   = !chip_sel_n && !blocked;
  wire       wr_act     = selected && !write_n;
  wire       rd_act     = selected && write_n && !out_en_n;
  wire       wr_edge    = wr_act && !prev_we_r;
  wire       is_clk     = (addr_pins[10:3] == CLK_BASE_HI);
  wire [2:0] clk_idx    = addr_pins[2:0];
  wire       mem_we     = wr_edge && !is_clk;
  wire       clk_we     = wr_edge && is_clk;
  wire       tick       = osc_in && !osc_d_r;
  wire       frozen     = ctrl_r[CTRL_READ_BIT] || ctrl_r[CTRL_LOAD_BIT];
  wire       load_start = clk_we && (clk_idx == 3'd0) && ctrl_r[CTRL_LOAD_BIT]
                          && !data_pins_in[CTRL_LOAD_BIT];
  wire       cnt_load   = (upd_r == LOAD);
  wire [7:0] cnt_byte [8];

  assign cnt_byte[0] = 8'h00;
  assign cnt_byte[1] = c_sec;
  assign cnt_byte[2] = c_min;
  assign cnt_byte[3] = c_hour;
  assign cnt_byte[4] = c_dow;
  assign cnt_byte[5] = c_date;
  assign cnt_byte[6] = c_month;
  assign cnt_byte[7] = c_year;

  assign data_pins_out_nxt = rd_clk_r ? hold_r[rd_idx_r] : mem_rdata;

  rtc_sram_mem u_mem (
    .mclk  (mclk),
    .we    (mem_we),
    .addr  (addr_pins),
    .wdata (data_pins_in),
    .rdata (mem_rdata)
  );

  rtc_counters u_cnt (
    .mclk     (mclk),
    .rst      (rst),
    .tick     (tick),
    .load     (cnt_load),
    .ld_sec   (hold_r[1]),
    .ld_min   (hold_r[2]),
    .ld_hour  (hold_r[3]),
    .ld_dow   (hold_r[4]),
    .ld_date  (hold_r[5]),
    .ld_month (hold_r[6]),
    .ld_year  (hold_r[7]),
    .sec_r    (c_sec),
    .min_r    (c_min),
    .hour_r   (c_hour),
    .dow_r    (c_dow),
    .date_r   (c_date),
    .month_r  (c_month),
    .year_r   (c_year)
  );

  // strobes and power-fail delay
  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_d_r             <= 1'b0;
      pf_blk_r            <= 1'b0;
      prev_we_r           <= 1'b0;
      power_fail_active_r <= 1'b0;
    end else begin
      osc_d_r             <= osc_in;
      pf_blk_r            <= power_fail;
      prev_we_r           <= wr_act;
      power_fail_active_r <= blocked;
    end
  end

  // read path: data valid two cycles after select
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_sel_r      <= 1'b0;
      rd_clk_r      <= 1'b0;
      rd_idx_r      <= 3'd0;
      data_pins_out <= 8'h00;
      data_pins_oe  <= 1'b0;
    end else begin
      rd_sel_r      <= rd_act;
      rd_clk_r      <= is_clk;
      rd_idx_r      <= clk_idx;
      data_pins_out <= data_pins_out_nxt;
      data_pins_oe  <= rd_act && rd_sel_r;
    end
  end

  // control register and holding cells; refresh copies counter bytes 1 to 7 in one cycle, skipping any byte the host writes that cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r    <= CTRL_RESET;
      upd_r     <= IDLE;
      for (int i = 0; i < 8; i++) begin
        hold_r[i] <= 8'h00;
      end
    end else begin
      if (clk_we) begin
        hold_r[clk_idx] <= data_pins_in;
        if (clk_idx == 3'd0) begin
          ctrl_r <= data_pins_in;
        end
      end
      case (upd_r)
        IDLE: begin
          if (load_start) begin
            upd_r <= LOAD;
          end else if (tick && !frozen) begin
            upd_r <= REFRESH;
          end
        end
        REFRESH: begin
          // a freeze arriving now still lets this refresh finish
          for (int i = 1; i < 8; i++) begin
            if (!(clk_we && clk_idx == i[2:0])) begin
              hold_r[i] <= cnt_byte[i];
            end
          end
          upd_r <= IDLE;
        end
        LOAD: begin
          upd_r <= IDLE;
        end
        default: begin
          upd_r <= IDLE;
        end
      endcase
    end
  end
endmodule : rtc_sram

/* tb/rtc_sram_asserts.sv */
/* pin-level assertions for rtc_sram.
   assumes one mclk domain with synchronous active-high rst; bound below. */
module rtc_sram_asserts (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        write_n,
  input wire logic [10:0] addr_pins,
  input wire logic [7:0]  data_pins_in,
  input wire logic [7:0]  data_pins_out,
  input wire logic        data_pins_oe,
  input wire logic        power_fail,
  input wire logic        osc_in,
  input wire logic        power_fail_active_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic rd_c;
  assign rd_c = !chip_sel_n && write_n && !out_en_n;
  deselect_float_a: assert property (chip_sel_n |=> !data_pins_oe) else $error("driven while deselected");
  write_float_a: assert property (!chip_sel_n && !write_n |=> !data_pins_oe) else $error("driven in write");
  idle_float_a: assert property (!chip_sel_n && write_n && out_en_n |=> !data_pins_oe)
    else $error("driven with output enable off");
  read_drive_a: assert property ((rd_c && !power_fail) [*4] |-> data_pins_oe) else $error("read not driven");
  oe_rise_a: assert property ($rose(data_pins_oe) |-> $past(rd_c, 2) && $past(rd_c))
    else $error("output enable rose without read");
  pf_float_a: assert property (power_fail |=> !data_pins_oe && power_fail_active_r)
    else $error("not blocked in power fail");
  pf_hold_a: assert property (power_fail ##1 !power_fail |=> power_fail_active_r)
    else $error("block flag dropped early");
  pf_clear_a: assert property (!power_fail [*2] |=> !power_fail_active_r) else $error("block flag stuck");
  cover property (rd_c ##2 data_pins_oe);
  cover property (!chip_sel_n && !write_n);
  cover property (power_fail && !chip_sel_n);
endmodule : rtc_sram_asserts

bind rtc_sram rtc_sram_asserts u_rtc_sram_asserts (
  .mclk(mclk), .rst(rst), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_n(write_n),
  .addr_pins(addr_pins), .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
  .data_pins_oe(data_pins_oe), .power_fail(power_fail), .osc_in(osc_in),
  .power_fail_active_r(power_fail_active_r));

/* tb/host_model.sv */
/* host side: drives sram strobes, power-fail flag and oscillator level.
   assumes mclk from the bench; requests change just after a rising edge. */
module host_model (
  input  wire logic        mclk,
  input  wire logic [7:0]  data_pins_out,
  input  wire logic        data_pins_oe,
  output logic             chip_sel_n,
  output logic             out_en_n,
  output logic             write_n,
  output logic      [10:0] addr_pins,
  output logic      [7:0]  data_pins_in,
  output logic             power_fail,
  output logic             osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_sel_n   = 1'b1;
    write_n      = 1'b1;
    out_en_n     = 1'b1;
    addr_pins    = 11'h000;
    data_pins_in = 8'h00;
    power_fail   = 1'b0;
    osc_in       = 1'b0;
  end
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk);
    chip_sel_n   <= 1'b0;
    write_n      <= 1'b0;
    addr_pins    <= a;
    data_pins_in <= d;
    @(posedge mclk);
    chip_sel_n   <= 1'b1;
    write_n      <= 1'b1;
    data_pins_in <= ~d;
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic oe);
    @(posedge mclk);
    chip_sel_n <= 1'b0;
    out_en_n   <= 1'b0;
    addr_pins  <= a;
    repeat (3) @(posedge mclk);
    d = data_pins_out;
    oe = data_pins_oe;
    chip_sel_n <= 1'b1;
    out_en_n   <= 1'b1;
  endtask : rd
  task automatic wr_oe(input logic [10:0] a, input logic [7:0] d, output logic oe);
    @(posedge mclk);
    chip_sel_n   <= 1'b0;
    write_n      <= 1'b0;
    out_en_n     <= 1'b0;
    addr_pins    <= a;
    data_pins_in <= d;
    repeat (3) @(posedge mclk);
    oe = data_pins_oe;
    chip_sel_n   <= 1'b1;
    write_n      <= 1'b1;
    out_en_n     <= 1'b1;
    data_pins_in <= ~d;
  endtask : wr_oe
  task automatic sel_idle(input logic [10:0] a, output logic oe);
    @(posedge mclk);
    chip_sel_n <= 1'b0;
    addr_pins  <= a;
    repeat (3) @(posedge mclk);
    oe = data_pins_oe;
    chip_sel_n <= 1'b1;
  endtask : sel_idle
  task automatic tick();
    @(posedge mclk);
    osc_in <= 1'b1;
    repeat (4) @(posedge mclk);
    osc_in <= 1'b0;
  endtask : tick
  task automatic set_pf(input logic v);
    @(posedge mclk);
    power_fail <= v;
  endtask : set_pf
endmodule : host_model

/* tb/testbench.sv */
/* self-checking bench: ram, clock bytes, calendar roll, freeze, power fail.
   assumes host_model drives the bus; mclk at 200 mhz made here. */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rtc_sram_pkg::*;
  logic       mclk;
  logic       rst;
  wire logic  cs_n, oe_n, wr_n, pf, osc, oe, pfa;
  wire logic [10:0] addr;
  wire logic [7:0]  din, dout;
  logic [7:0] rv;
  logic       roe;
  int         err_count;
  int         checks_done;
  logic [7:0] tv [7];
  logic [7:0] ex [7];
  logic [7:0] cd [3] = '{8'h28, 8'h28, 8'h30};
  logic [7:0] cm [3] = '{8'h02, 8'h02, 8'h04};
  logic [7:0] cy [3] = '{8'h01, 8'h04, 8'h05};
  logic [7:0] ed [3] = '{8'h01, 8'h29, 8'h01};
  logic [7:0] em [3] = '{8'h03, 8'h02, 8'h05};
  rtc_sram u_rtc_sram (.mclk(mclk), .rst(rst), .chip_sel_n(cs_n), .out_en_n(oe_n), .write_n(wr_n),
    .addr_pins(addr), .data_pins_in(din), .data_pins_out(dout), .data_pins_oe(oe),
    .power_fail(pf), .osc_in(osc), .power_fail_active_r(pfa));
  host_model u_host_model (.mclk(mclk), .data_pins_out(dout), .data_pins_oe(oe), .chip_sel_n(cs_n),
    .out_en_n(oe_n), .write_n(wr_n), .addr_pins(addr), .data_pins_in(din), .power_fail(pf), .osc_in(osc));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  task automatic cmp(input string n, input logic [8:0] e, input logic [8:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic chk(input logic [10:0] a, input logic [7:0] e);
    u_host_model.rd(a, rv, roe);
    cmp($sformatf("byte %h", a), {1'b1, e}, {roe, rv});
  endtask : chk
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    u_host_model.tick();
    chk(SEC_ADDR, SEC_RESET);
    u_host_model.wr(11'h000, 8'ha5);
    u_host_model.wr(11'h7f7, 8'h5a);
    u_host_model.wr(11'h000, 8'h3c);
    chk(11'h000, 8'h3c);
    chk(11'h7f7, 8'h5a);
    u_host_model.wr_oe(11'h010, 8'h96, roe);
    cmp("oe in write", 9'h000, {8'h00, roe});
    chk(11'h010, 8'h96);
    u_host_model.sel_idle(11'h010, roe);
    cmp("oe with output enable off", 9'h000, {8'h00, roe});
    u_host_model.wr(CTRL_ADDR, 8'h25);
    chk(CTRL_ADDR, 8'h25);
    for (int k = 0; k < 3; k++) begin
      tv = '{8'h59, 8'h59, 8'h23, 8'h07, cd[k], cm[k], cy[k]};
      ex = '{8'h00, 8'h00, 8'h00, 8'h01, ed[k], em[k], cy[k]};
      u_host_model.wr(CTRL_ADDR, 8'h80);
      for (int i = 0; i < 7; i++) u_host_model.wr(SEC_ADDR + 11'(i), tv[i]);
      u_host_model.wr(CTRL_ADDR, 8'h00);
      u_host_model.tick();
      for (int i = 0; i < 7; i++) chk(SEC_ADDR + 11'(i), ex[i]);
    end
    u_host_model.wr(CTRL_ADDR, 8'h40);
    u_host_model.tick();
    chk(SEC_ADDR, 8'h00);
    u_host_model.wr(CTRL_ADDR, 8'h00);
    u_host_model.tick();
    chk(SEC_ADDR, 8'h02);
    u_host_model.set_pf(1'b1);
    u_host_model.wr(11'h000, 8'hff);
    u_host_model.rd(11'h000, rv, roe);
    cmp("oe in power fail", 9'h000, {8'h00, roe});
    cmp("block flag", 9'h001, {8'h00, pfa});
    u_host_model.set_pf(1'b0);
    chk(11'h000, 8'h3c);
    cmp("block flag clear", 9'h000, {8'h00, pfa});
    finish_test();
  end
endmodule : testbench
